// [rtl/dsc_pkg.sv]
// constants, field layout and types of the instruction decoder
// assumes one 24-bit program word per clock from the fetch unit
// Summary of operation
// RQ1 - a single word is 24 bits: 8-bit opcode, operands below it.
// RQ2 - double words hold 48 bits; second word's top 8 bits zero, alone a nop.
// RQ3 - only three opcodes occupy two program words, all others one.
// RQ4 - every double-word instruction takes two cycles.
// RQ5 - single word takes one cycle, two if condition true or pc changes.
// RQ6 - jumps, indirect calls, table ops and returns take two or three cycles.
// RQ7 - taken skip costs two cycles, three when the skipped one is double.
// RQ8 - double-word moves take two cycles.
// RQ9 - register ops decode base source, second source and result destination.
// RQ10 - file ops decode an address and a destination: file or register 0.
// RQ11 - bit ops take the bit from a literal or from the base register.
// RQ12 - multiply-sum ops decode accumulator, pair, prefetches and write-back.
// RQ13 - other dsp ops decode accumulator, operand and shift amount.
// RQ14 - file addresses span zero to 0x1fff.
// RQ15 - accumulator write-back only to register 13 or its post-increment by two.
// RQ16 - ten-bit literal limited to 255 in byte mode, 1023 in word mode.
// RQ17 - the 23-bit program address literal has a zero lsb.
// RQ18 - five integer flags kept: carry, digit carry, negative, overflow, zero.
// RQ19 - per-accumulator overflow and saturate flags, updated by accumulator ops.
// RQ20 - size suffix selects byte, double word or word; word is the default.
// RQ21 - word bit ops use a 4-bit select for bits 0 to 15.
// RQ22 - a squashed cycle changes no register, memory or flag.
package dsc_pkg;
  localparam int WORD_W = 24;
  localparam int OPC_LSB = 16;
  localparam int REG_W = 4;
  localparam int MODE_W = 2;
  localparam int FILE_W = 13;
  localparam int LIT_W = 10;
  localparam int SHIFT_W = 6;
  localparam int PA_HI_W = 7;
  // operand field positions in the low 16 bits of a word
  localparam int F_SRC2 = 0;
  localparam int F_SRC2_MODE = 4;
  localparam int F_DEST = 6;
  localparam int F_DEST_MODE = 10;
  localparam int F_BASE = 12;
  localparam int F_FILE = 0;
  localparam int F_FILE_KEEP = 13;
  localparam int F_BITSEL = 12;
  localparam int F_LIT = 4;
  localparam int F_ACC = 15;
  localparam int F_SHIFT_REG = 14;
  localparam int F_SHIFT = 8;
  localparam int F_MUL = 12;
  localparam int F_XPF = 9;
  localparam int F_XDST = 7;
  localparam int F_YPF = 4;
  localparam int F_YDST = 2;
  localparam int F_WBACK = 0;
  localparam int F_PA_HI = 0;
  localparam logic [7:0] OPC_NOP = 8'h00;
  localparam logic [7:0] OPC_BRANCH = 8'h01;
  localparam logic [7:0] OPC_BRANCH_COND = 8'h02;
  localparam logic [7:0] OPC_CALL_IND = 8'h03;
  localparam logic [7:0] OPC_GOTO_IND = 8'h04;
  localparam logic [7:0] OPC_GOTO2 = 8'h05;
  localparam logic [7:0] OPC_CALL2 = 8'h06;
  localparam logic [7:0] OPC_LOOP2 = 8'h07;
  localparam logic [7:0] OPC_RETURN = 8'h08;
  localparam logic [7:0] OPC_INT_RETURN = 8'h09;
  localparam logic [7:0] OPC_TABLE_RD = 8'h0a;
  localparam logic [7:0] OPC_TABLE_WR = 8'h0b;
  localparam logic [7:0] OPC_SKIP = 8'h0c;
  localparam logic [7:0] OPC_MOVD = 8'h0d;
  localparam logic [7:0] OPC_REG3_LO = 8'h10;
  localparam logic [7:0] OPC_FILE_LO = 8'h40;
  localparam logic [7:0] OPC_BIT_LO = 8'h60;
  localparam logic [7:0] OPC_LIT_LO = 8'h80;
  localparam logic [7:0] OPC_MULSUM_LO = 8'ha0;
  localparam logic [7:0] OPC_DSP_LO = 8'hc0;
  localparam logic [7:0] OPC_DSP_HI = 8'hdf;
  localparam logic [7:0] W2_HI = 8'h00;
  localparam logic [12:0] FILE_MAX = 13'h1fff;
  localparam logic [9:0] LIT_BYTE_MAX = 10'h0ff;
  localparam logic [2:0] MUL_PAIR_MAX = 3'h5;
  localparam logic [1:0] WBACK_DIRECT = 2'h1;
  localparam logic [1:0] WBACK_POSTINC = 2'h2;
  localparam logic [1:0] WBACK_BAD = 2'h3;
  localparam logic [3:0] WBACK_REG = 4'hd;
  localparam logic [1:0] EXTRA_NONE = 2'h0;
  localparam logic [1:0] EXTRA_JUMP = 2'h1;
  localparam logic [1:0] EXTRA_RET = 2'h2;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_DIGIT_CARRY = 1;
  localparam int FLAG_NEG = 2;
  localparam int FLAG_OVERFLOW = 3;
  localparam int FLAG_ZERO = 4;
  localparam int FLAG_SUM_A_OVF = 0;
  localparam int FLAG_SUM_B_OVF = 1;
  localparam int FLAG_SUM_A_SAT = 2;
  localparam int FLAG_SUM_B_SAT = 3;
  localparam logic [4:0] INT_FLAGS_RST = 5'h00;
  localparam logic [3:0] ACC_FLAGS_RST = 4'h0;
  typedef enum logic [2:0] {
    CL_NOP, CL_REG3, CL_FILE, CL_BIT, CL_LIT, CL_MULSUM, CL_DSP, CL_CTRL
  } op_class_t;
  typedef enum logic [1:0] {SZ_WORD, SZ_BYTE, SZ_DWORD} size_t;
endpackage

// [rtl/dsc_status_flags.sv]
// integer and accumulator status flags of the core
// assumes the datapath offers new flag values in the issue cycle
`timescale 1ns/1ps
module dsc_status_flags
  import dsc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic exec_en_in,
  input wire logic acc_class_in,
  input wire logic int_we_in,
  input wire logic [4:0] int_flags_in,
  input wire logic sticky_z_in,
  input wire logic acc_we_in,
  input wire logic [3:0] acc_flags_in,
  output logic [4:0] int_flags_out,
  output logic [3:0] acc_flags_out
);
  logic upd_int;
  logic upd_acc;
  logic [4:0] int_nxt;

  // squashed cycles never raise exec_en, so flags hold [RQ22]
  assign upd_int = exec_en_in && !acc_class_in && int_we_in; // [RQ19]
  assign upd_acc = exec_en_in && acc_class_in && acc_we_in; // [RQ19]

  // zero may only stay or fall in multi-precision chains
  always_comb begin
    int_nxt = int_flags_in;
    if (sticky_z_in) begin
      int_nxt[FLAG_ZERO] = int_flags_out[FLAG_ZERO] &&
                           int_flags_in[FLAG_ZERO]; // [RQ18]
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      int_flags_out <= INT_FLAGS_RST;
    end else if (upd_int) begin
      int_flags_out <= int_nxt; // [RQ18]
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_flags_out <= ACC_FLAGS_RST;
    end else if (upd_acc) begin
      acc_flags_out <= acc_flags_in; // [RQ19]
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_quiet_flags: assert property ( // [RQ22]
    !exec_en_in |=> $stable(int_flags_out) && $stable(acc_flags_out))
    else $error("flags changed without an issued instruction");
  a_acc_only: assert property ( // [RQ19]
    exec_en_in && acc_class_in |=> $stable(int_flags_out))
    else $error("accumulator op touched integer flags");
  a_zero_sticky: assert property ( // [RQ18]
    upd_int && sticky_z_in && !int_flags_out[FLAG_ZERO]
    |=> !int_flags_out[FLAG_ZERO])
    else $error("sticky zero flag was set");
endmodule

// [rtl/dsc_instruction_format_timing.sv]
// instruction word decoder and cycle sequencer of the core
// assumes the fetch unit offers words with valid, taken on ready
`timescale 1ns/1ps
module dsc_instruction_format_timing
  import dsc_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic instr_valid_in,
  input wire logic [WORD_W-1:0] instr_in,
  input wire logic cond_true_in,
  input wire logic [15:0] base_val_in,
  input wire logic int_we_in,
  input wire logic [4:0] int_flags_in,
  input wire logic sticky_z_in,
  input wire logic acc_we_in,
  input wire logic [3:0] acc_flags_in,
  output logic fetch_ready_out,
  output logic issue_out,
  output logic nop_cycle_out,
  output logic illegal_out,
  output logic [1:0] cycles_out,
  output op_class_t op_class_out,
  output size_t size_out,
  output logic [3:0] base_source_reg_out,
  output logic [3:0] second_source_reg_out,
  output logic [1:0] second_source_mode_out,
  output logic [3:0] result_dest_reg_out,
  output logic [1:0] result_dest_mode_out,
  output logic [12:0] file_addr_out,
  output logic file_to_default_reg_out,
  output logic [3:0] bit_select_field_out,
  output logic [9:0] ten_bit_literal_out,
  output logic acc_b_out,
  output logic shift_by_reg_out,
  output logic [2:0] mul_pair_out,
  output logic [2:0] x_prefetch_out,
  output logic [1:0] x_dest_out,
  output logic [2:0] y_prefetch_out,
  output logic [1:0] y_dest_out,
  output logic sum_writeback_en_out,
  output logic sum_writeback_inc_out,
  output logic [3:0] sum_writeback_target_out,
  output logic [22:0] program_address_literal_out,
  output logic [4:0] int_flags_out,
  output logic [3:0] acc_flags_out
);
  typedef enum logic [1:0] {ST_RUN, ST_WORD2, ST_HOLD} state_t;

  logic [1:0] rst_sync_r;
  logic rst_n;
  state_t state_r;
  state_t state_nxt;
  logic [1:0] hold_r;
  logic skip_pend_r;
  logic squash2_r;
  logic [15:0] pa_lo_r;
  logic take;
  logic fresh;
  logic squash_take;
  logic word2_take;
  logic [7:0] opc;
  logic [15:0] ops;
  op_class_t cls;
  logic dword;
  logic byte_op;
  logic [1:0] extra;
  logic [1:0] wback;
  logic [9:0] ten_bit_literal;
  logic bad_fields;

  function automatic op_class_t class_of(input logic [7:0] o);
    if (o > OPC_DSP_HI) class_of = CL_NOP;
    else if (o >= OPC_DSP_LO) class_of = CL_DSP;
    else if (o >= OPC_MULSUM_LO) class_of = CL_MULSUM;
    else if (o >= OPC_LIT_LO) class_of = CL_LIT;
    else if (o >= OPC_BIT_LO) class_of = CL_BIT;
    else if (o >= OPC_FILE_LO) class_of = CL_FILE;
    else if (o >= OPC_REG3_LO) class_of = CL_REG3;
    else if (o > OPC_NOP && o <= OPC_MOVD) class_of = CL_CTRL;
    else class_of = CL_NOP;
  endfunction

  function automatic logic known(input logic [7:0] o);
    known = o <= OPC_DSP_HI && !(o > OPC_MOVD && o < OPC_REG3_LO);
  endfunction

  function automatic logic is_dword(input logic [7:0] o);
    is_dword = o == OPC_GOTO2 || o == OPC_CALL2 || o == OPC_LOOP2;
  endfunction

  // cycles beyond the first that the sequencer spends as nops
  function automatic logic [1:0] extra_of(input logic [7:0] o,
                                          input logic c);
    case (o)
      OPC_BRANCH, OPC_CALL_IND, OPC_GOTO_IND: extra_of = EXTRA_JUMP;
      OPC_TABLE_RD, OPC_TABLE_WR: extra_of = EXTRA_JUMP;
      OPC_MOVD: extra_of = EXTRA_JUMP;
      OPC_RETURN, OPC_INT_RETURN: extra_of = EXTRA_RET;
      OPC_BRANCH_COND: extra_of = c ? EXTRA_JUMP : EXTRA_NONE;
      default: extra_of = EXTRA_NONE;
    endcase
  endfunction

  function automatic logic [15:0] fld(input logic [15:0] w,
                                      input int lsb);
    fld = w >> lsb;
  endfunction

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  assign opc = instr_in[WORD_W-1:OPC_LSB]; // [RQ1]
  assign ops = instr_in[OPC_LSB-1:0];
  assign cls = class_of(opc);
  assign dword = is_dword(opc); // [RQ3]
  assign byte_op = opc[0] &&
                   (cls == CL_REG3 || cls == CL_FILE || cls == CL_LIT);
  assign extra = extra_of(opc, cond_true_in);
  assign take = instr_valid_in && fetch_ready_out;
  assign fresh = take && state_r == ST_RUN && !skip_pend_r;
  assign squash_take = take && state_r == ST_RUN && skip_pend_r;
  assign word2_take = take && state_r == ST_WORD2;
  assign wback = MODE_W'(fld(ops, F_WBACK));
  assign ten_bit_literal = LIT_W'(fld(ops, F_LIT));

  always_comb begin
    bad_fields = !known(opc);
    if (cls == CL_LIT && byte_op && ten_bit_literal > LIT_BYTE_MAX) begin
      bad_fields = 1'b1; // [RQ16]
    end
    if (cls == CL_MULSUM &&
        (wback == WBACK_BAD || 3'(fld(ops, F_MUL)) > MUL_PAIR_MAX)) begin
      bad_fields = 1'b1; // [RQ15]
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (take && dword) begin
          state_nxt = ST_WORD2; // [RQ4]
        end else if (fresh && extra != EXTRA_NONE) begin
          state_nxt = ST_HOLD; // [RQ5] [RQ6] [RQ8]
        end
      end
      ST_WORD2: begin
        if (take) begin
          state_nxt = ST_RUN;
        end
      end
      ST_HOLD: begin
        if (hold_r == EXTRA_JUMP) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_RUN;
      hold_r <= EXTRA_NONE;
      skip_pend_r <= 1'b0;
      squash2_r <= 1'b0;
      fetch_ready_out <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // stalling the fetch is what makes a hold cycle a nop
      fetch_ready_out <= state_nxt != ST_HOLD;
      if (fresh) begin
        hold_r <= extra;
      end else if (state_r == ST_HOLD) begin
        hold_r <= hold_r - EXTRA_JUMP;
      end
      if (take && state_r == ST_RUN) begin
        skip_pend_r <= fresh && opc == OPC_SKIP && cond_true_in; // [RQ7]
        squash2_r <= skip_pend_r && dword; // [RQ7]
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      issue_out <= 1'b0;
      nop_cycle_out <= 1'b0;
      cycles_out <= CYC_ONE;
      illegal_out <= 1'b0;
    end else begin
      issue_out <= (fresh && !dword) || (word2_take && !squash2_r);
      nop_cycle_out <= state_r == ST_HOLD || squash_take ||
                       (word2_take && squash2_r); // [RQ22]
      if (fresh && !dword) begin
        cycles_out <= CYC_ONE + extra; // [RQ5] [RQ6]
      end else if (squash_take) begin
        cycles_out <= dword ? CYC_THREE : CYC_TWO; // [RQ7]
      end else if (word2_take && !squash2_r) begin
        cycles_out <= CYC_TWO; // [RQ4]
      end
      if (fresh) begin
        illegal_out <= bad_fields;
      end else if (word2_take) begin
        illegal_out <= illegal_out || opc != W2_HI || pa_lo_r[0]; // [RQ2]
      end
    end
  end

  // a lone second word has opcode zero and so decodes as a nop
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      op_class_out <= CL_NOP;
      size_out <= SZ_WORD;
      base_source_reg_out <= 4'h0;
      second_source_reg_out <= 4'h0;
      second_source_mode_out <= 2'h0;
      result_dest_reg_out <= 4'h0;
      result_dest_mode_out <= 2'h0;
      file_addr_out <= 13'h0000;
      file_to_default_reg_out <= 1'b0;
      bit_select_field_out <= 4'h0;
      ten_bit_literal_out <= 10'h000;
      acc_b_out <= 1'b0;
      shift_by_reg_out <= 1'b0;
    end else if (fresh) begin
      op_class_out <= cls; // [RQ2]
      if (opc == OPC_MOVD) begin
        size_out <= SZ_DWORD; // [RQ20]
      end else begin
        size_out <= byte_op ? SZ_BYTE : SZ_WORD; // [RQ20]
      end
      // dsp ops carry their shift register in the shift amount field
      base_source_reg_out <= cls == CL_DSP ? REG_W'(fld(ops, F_SHIFT))
                             : REG_W'(fld(ops, F_BASE)); // [RQ9] [RQ13]
      second_source_reg_out <= REG_W'(fld(ops, F_SRC2)); // [RQ9]
      second_source_mode_out <= MODE_W'(fld(ops, F_SRC2_MODE));
      result_dest_reg_out <= REG_W'(fld(ops, F_DEST)); // [RQ9]
      result_dest_mode_out <= MODE_W'(fld(ops, F_DEST_MODE));
      file_addr_out <= FILE_W'(fld(ops, F_FILE)) & FILE_MAX; // [RQ14]
      file_to_default_reg_out <= !ops[F_FILE_KEEP]; // [RQ10]
      // indirect select uses the low nibble of the base register
      bit_select_field_out <= cls == CL_BIT && opc[0] ? base_val_in[3:0]
                              : REG_W'(fld(ops, F_BITSEL)); // [RQ11] [RQ21]
      if (cls == CL_DSP) begin
        ten_bit_literal_out <= LIT_W'(SHIFT_W'(fld(ops, F_SHIFT)));
      end else begin
        ten_bit_literal_out <= byte_op ? (ten_bit_literal & LIT_BYTE_MAX)
                               : ten_bit_literal; // [RQ16]
      end
      acc_b_out <= ops[F_ACC]; // [RQ12] [RQ13]
      shift_by_reg_out <= cls == CL_DSP && ops[F_SHIFT_REG]; // [RQ13]
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      mul_pair_out <= 3'h0;
      x_prefetch_out <= 3'h0;
      x_dest_out <= 2'h0;
      y_prefetch_out <= 3'h0;
      y_dest_out <= 2'h0;
      sum_writeback_en_out <= 1'b0;
      sum_writeback_inc_out <= 1'b0;
      sum_writeback_target_out <= 4'h0;
    end else if (fresh) begin
      mul_pair_out <= 3'(fld(ops, F_MUL)); // [RQ12]
      x_prefetch_out <= 3'(fld(ops, F_XPF));
      x_dest_out <= 2'(fld(ops, F_XDST));
      y_prefetch_out <= 3'(fld(ops, F_YPF));
      y_dest_out <= 2'(fld(ops, F_YDST));
      sum_writeback_en_out <= cls == CL_MULSUM &&
        (wback == WBACK_DIRECT || wback == WBACK_POSTINC); // [RQ15]
      sum_writeback_inc_out <= wback == WBACK_POSTINC; // [RQ15]
      sum_writeback_target_out <= WBACK_REG; // [RQ15]
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pa_lo_r <= 16'h0000;
      program_address_literal_out <= 23'h000000;
    end else if (fresh && dword) begin
      pa_lo_r <= ops;
    end else if (word2_take && !squash2_r) begin
      // odd addresses are flagged and forced even
      program_address_literal_out <= {PA_HI_W'(fld(ops, F_PA_HI)),
                                      pa_lo_r[15:1], 1'b0}; // [RQ17]
    end
  end

  dsc_status_flags u_flags (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .exec_en_in(issue_out),
    .acc_class_in(op_class_out == CL_MULSUM || op_class_out == CL_DSP),
    .int_we_in(int_we_in),
    .int_flags_in(int_flags_in),
    .sticky_z_in(sticky_z_in),
    .acc_we_in(acc_we_in),
    .acc_flags_in(acc_flags_in),
    .int_flags_out(int_flags_out),
    .acc_flags_out(acc_flags_out)
  );

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n);

  sequence s_fresh_op(logic [7:0] o);
    fresh && opc == o;
  endsequence
  sequence s_skip_taken;
    fresh && opc == OPC_SKIP && cond_true_in;
  endsequence
  sequence s_one_hold;
    !fetch_ready_out ##1 fetch_ready_out && nop_cycle_out;
  endsequence

  a_dword_two: assert property ( // [RQ4]
    fresh && dword ##1 take |=> issue_out && cycles_out == CYC_TWO)
    else $error("double word not completed in two cycles");
  a_only_three: assert property ( // [RQ3]
    fresh && !dword |=> state_r != ST_WORD2)
    else $error("single word waited for a second word");
  a_word2_zero: assert property ( // [RQ2]
    word2_take && opc != W2_HI |=> illegal_out)
    else $error("bad second word not flagged");
  a_cond_taken: assert property ( // [RQ5]
    s_fresh_op(OPC_BRANCH_COND) and cond_true_in
    |=> issue_out ##0 s_one_hold)
    else $error("taken branch lacks one nop cycle");
  a_return_three: assert property ( // [RQ6]
    s_fresh_op(OPC_RETURN) |=> !fetch_ready_out [*2] ##1 fetch_ready_out)
    else $error("return not three cycles");
  a_skip_single: assert property ( // [RQ7]
    s_skip_taken ##1 (take && !dword)
    |=> nop_cycle_out && !issue_out && cycles_out == CYC_TWO)
    else $error("skip over single word wrong");
  a_skip_double: assert property ( // [RQ7]
    s_skip_taken ##1 (take && dword) ##1 take
    |=> nop_cycle_out && !issue_out && cycles_out == CYC_THREE)
    else $error("skip over double word wrong");
  a_movd_two: assert property ( // [RQ8]
    s_fresh_op(OPC_MOVD) |=> size_out == SZ_DWORD ##0 s_one_hold)
    else $error("double move not two cycles");
  a_lit_byte: assert property ( // [RQ16]
    issue_out && op_class_out == CL_LIT && size_out == SZ_BYTE
    |-> ten_bit_literal_out <= LIT_BYTE_MAX)
    else $error("byte literal above 255");
  a_wback_bad: assert property ( // [RQ15]
    fresh && cls == CL_MULSUM && wback == WBACK_BAD
    |=> !sum_writeback_en_out && illegal_out)
    else $error("illegal write-back accepted");
  a_pa_even: assert property ( // [RQ17]
    word2_take |=> !program_address_literal_out[0])
    else $error("odd program address");
  a_squash_quiet: assert property ( // [RQ22]
    squash_take |=> !issue_out && $stable(op_class_out))
    else $error("squashed word was issued");
endmodule

// [bench/fetch_model.sv]
// program memory fetch unit model offering queued words to the decoder
// assumes words leave only at the falling edge after a take
`timescale 1ns/1ps
module fetch_model (
  input wire logic clk_in,
  input wire logic ready_in,
  output logic valid_out,
  output logic [23:0] word_out,
  output logic cond_out
);
  logic [24:0] q[$];
  logic took;
  initial begin
    valid_out = 1'b0;
    word_out = 24'h000000;
    cond_out = 1'b0;
    took = 1'b0;
  end
  always @(posedge clk_in) begin
    took <= valid_out && ready_in;
  end
  // double words are queued as a pair so the second word follows
  always @(negedge clk_in) begin
    if (took && q.size() > 0) begin
      void'(q.pop_front());
    end
    if (q.size() > 0) begin
      valid_out <= 1'b1;
      {cond_out, word_out} <= q[0];
    end else begin
      // idle bus: toggle the word so no stale value looks valid
      valid_out <= 1'b0;
      word_out <= ~word_out;
      cond_out <= ~cond_out;
    end
  end
endmodule

// [bench/tb_top.sv]
// self-checking bench of the instruction decoder
// assumes the fetch model feeds words; bench drives the rest at negedge
`timescale 1ns/1ps
module tb_top;
  import dsc_pkg::*;
  typedef struct {
    logic [23:0] w;
    logic c;
    logic [1:0] cyc;
    op_class_t cls;
    int sel;
    logic [22:0] fv;
  } row_t;
  logic sys_clk_in, arst_n_in, cond, valid, ready, issue, nop, illegal;
  logic [23:0] word;
  logic [15:0] base_val;
  logic int_we, acc_we;
  logic [4:0] int_fl, int_fl_o;
  logic [3:0] acc_fl, acc_fl_o, dst, bsel, wtgt;
  logic [1:0] cyc_o;
  op_class_t cls_o;
  logic [12:0] faddr;
  logic [9:0] lit;
  logic [22:0] pal;
  logic f2d, wb_inc, shreg;
  logic accb, wben, sticky_z;
  logic [3:0] bsrc, src2;
  logic [2:0] mpair;
  size_t sz;
  int n_nop;
  int n_mismatch = 0;
  int cmp_count = 0;
  row_t rows[15];
  dsc_instruction_format_timing dsc_instruction_format_timing_inst (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .instr_valid_in(valid), .instr_in(word), .cond_true_in(cond),
    .base_val_in(base_val), .int_we_in(int_we), .int_flags_in(int_fl),
    .sticky_z_in(sticky_z), .acc_we_in(acc_we), .acc_flags_in(acc_fl),
    .fetch_ready_out(ready), .issue_out(issue), .nop_cycle_out(nop),
    .illegal_out(illegal), .cycles_out(cyc_o), .op_class_out(cls_o),
    .size_out(sz), .base_source_reg_out(bsrc),
    .second_source_reg_out(src2),
    .second_source_mode_out(), .result_dest_reg_out(dst),
    .result_dest_mode_out(), .file_addr_out(faddr),
    .file_to_default_reg_out(f2d), .bit_select_field_out(bsel),
    .ten_bit_literal_out(lit), .acc_b_out(accb), .shift_by_reg_out(shreg),
    .mul_pair_out(mpair), .x_prefetch_out(), .x_dest_out(),
    .y_prefetch_out(), .y_dest_out(), .sum_writeback_en_out(wben),
    .sum_writeback_inc_out(wb_inc), .sum_writeback_target_out(wtgt),
    .program_address_literal_out(pal), .int_flags_out(int_fl_o),
    .acc_flags_out(acc_fl_o));
  fetch_model fetch_model_inst (.clk_in(sys_clk_in), .ready_in(ready),
    .valid_out(valid), .word_out(word), .cond_out(cond));
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  task automatic chk(input logic [22:0] got, input logic [22:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  function automatic logic [22:0] pick(int sel);
    case (sel)
      1: return {11'h0, bsrc, src2, dst};
      2: return {9'h0, f2d, faddr};
      3: return {19'h0, bsel};
      4: return {11'h0, sz, lit};
      5: return {14'h0, mpair, wben, wb_inc, wtgt};
      6: return {21'h0, accb, shreg};
      7: return pal;
      8: return {21'h0, illegal, wben};
      default: return 23'h0;
    endcase
  endfunction
  // queue words, wait for the issue, let extra cycles run out
  task automatic run(input logic [24:0] a, input logic [24:0] b, int n);
    int k;
    fetch_model_inst.q.push_back(a);
    if (n > 1) fetch_model_inst.q.push_back(b);
    k = 0;
    while (issue !== 1'b1 && k < 20) begin
      @(negedge sys_clk_in);
      k++;
    end
    if (k == 20) chk(23'h1, 23'h0);
    n_nop = 0;
    repeat (5) begin
      @(negedge sys_clk_in);
      if (nop === 1'b1) n_nop++;
    end
  endtask
  initial begin
    rows = '{
      '{24'h103567, 0, CYC_ONE, CL_REG3, 1, 23'h375},
      '{24'h401fff, 0, CYC_ONE, CL_FILE, 2, 23'h3fff},
      '{24'h60f000, 0, CYC_ONE, CL_BIT, 3, 23'hf},
      '{24'h610000, 0, CYC_ONE, CL_BIT, 3, 23'h9},
      '{24'h803ff0, 0, CYC_ONE, CL_LIT, 4, 23'h3ff},
      '{24'h810ff0, 0, CYC_ONE, CL_LIT, 4, 23'h4ff},
      '{24'ha0a002, 0, CYC_ONE, CL_MULSUM, 5, 23'hbd},
      '{24'hc0c000, 0, CYC_ONE, CL_DSP, 6, 23'h3},
      '{24'h080000, 0, CYC_THREE, CL_CTRL, 0, 23'h0},
      '{24'h010000, 0, CYC_TWO, CL_CTRL, 0, 23'h0},
      '{24'h0a0000, 0, CYC_TWO, CL_CTRL, 0, 23'h0},
      '{24'h020000, 1, CYC_TWO, CL_CTRL, 0, 23'h0},
      '{24'h020000, 0, CYC_ONE, CL_CTRL, 0, 23'h0},
      '{24'ha0a003, 0, CYC_ONE, CL_MULSUM, 8, 23'h2},
      '{24'h811ff0, 0, CYC_ONE, CL_LIT, 4, 23'h4ff}
    };
    arst_n_in = 1'b0;
    base_val = 16'h0009;
    sticky_z = 1'b0;
    int_we = 1'b1;
    int_fl = 5'h0b;
    acc_we = 1'b1;
    acc_fl = 4'h5;
    repeat (4) @(negedge sys_clk_in);
    arst_n_in = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    chk({22'h0, ready}, 23'h1);
    foreach (rows[i]) begin
      run({rows[i].c, rows[i].w}, 25'h0, 1);
      chk({21'h0, cyc_o}, {21'h0, rows[i].cyc});
      chk({20'h0, cls_o}, {20'h0, rows[i].cls});
      if (rows[i].sel != 0) chk(pick(rows[i].sel), rows[i].fv);
      chk(23'(n_nop), {21'h0, rows[i].cyc} - 23'h1);
    end
    chk({18'h0, int_fl_o}, 23'hb);
    chk({19'h0, acc_fl_o}, 23'h5);
    sticky_z = 1'b1;
    int_fl = 5'h1f;
    run(25'h100000, 25'h0, 1);
    chk({18'h0, int_fl_o}, 23'hf);
    sticky_z = 1'b0;
    run(25'h050002, 25'h000041, 2);
    chk({21'h0, cyc_o}, 23'h2);
    chk(23'(n_nop), 23'h0);
    chk(pick(7), 23'h410002);
    run(25'h0d0000, 25'h0, 1);
    chk({21'h0, cyc_o}, 23'h2);
    chk(23'(n_nop), 23'h1);
    chk(pick(4), 23'h800);
    run(25'h000000, 25'h0, 1);
    chk({20'h0, cls_o}, {20'h0, CL_NOP});
    run(25'h10c000, 25'h0, 1);
    fetch_model_inst.q.push_back(25'h100000);
    run(25'h10c000, 25'h0, 1);
    run(25'h0c0000 | 25'h1000000, 25'h103567, 2);
    chk({21'h0, cyc_o}, 23'h2);
    chk(23'(n_nop), 23'h1);
    chk(pick(1), 23'h0);
    fetch_model_inst.q.push_back(25'h1000000 | 25'h0c0000);
    fetch_model_inst.q.push_back(25'h050002);
    run(25'h000041, 25'h0, 1);
    chk({21'h0, cyc_o}, 23'h3);
    chk(23'(n_nop), 23'h2);
    chk({22'h0, illegal}, 23'h0);
    arst_n_in = 1'b0;
    @(negedge sys_clk_in);
    chk({22'h0, ready}, 23'h0);
    chk({18'h0, int_fl_o}, 23'h0);
    chk({21'h0, cyc_o}, {21'h0, CYC_ONE});
    arst_n_in = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    run(25'h010000, 25'h0, 1);
    chk({21'h0, cyc_o}, 23'h2);
    print_verdict();
  end
  initial begin
    #200us;
    n_mismatch++;
    print_verdict();
  end
endmodule
